// File: rtl/fsa_alu.sv
// Single-operand ALU: passes, moves, format conversions, wrap, unwrap and shifts.
`default_nettype none

module fsa_alu
  import fsa_pkg::*;
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 srst_i,
  input  wire logic                 instr_valid_i,
  input  wire fsa_pkg::fsa_instr_t  instr_i,
  input  wire logic [31:0]          operand_a_data_i,
  input  wire logic [31:0]          operand_b_data_bus_i,
  output logic                      ready_o,
  output fsa_pkg::fsa_result_t      result_o,
  output logic                      result_valid_o,
  output fsa_pkg::fsa_mode_t        mode_o,
  output logic                      unsupported_o
);
  import fsa_pkg::*;

  // Leading-zero count of a 64-bit word; 64 when the word is zero.
  function automatic logic [6:0] lzc64(input logic [63:0] v);
    logic [6:0] n;
    n = 7'h40;
    for (int i = 0; i < 64; i++)
      if (v[i]) n = 7'(63 - i);
    return n;
  endfunction

  // Normalizes a mantissa (hidden bit at 63) and packs it at the given
  // precision, truncating. With wrap set, a tiny exponent is kept as a
  // two's complement field instead of being denormalized.
  function automatic fsa_result_t pack_fp(input logic s, input logic signed [13:0] be,
                                          input logic [63:0] m, input logic dp,
                                          input logic wrap);
    logic [6:0]         nz;
    logic [63:0]        mn;
    logic signed [13:0] bn;
    logic signed [13:0] emax;
    logic [5:0]         sh;
    logic [63:0]        ms;
    logic               lost;
    fsa_result_t        r;
    nz = lzc64(m);
    mn = m << nz[5:0];
    bn = be - 14'($signed({1'b0, nz}));
    emax = dp ? DP_EMAX : SP_EMAX;
    sh = 6'h0;
    if (!wrap && bn < 14'sh0001)
      sh = (bn < -14'sh003e) ? 6'h3f : 6'(14'sh0001 - bn);
    ms = mn >> sh;
    lost = |(mn & ~(64'hffff_ffff_ffff_ffff << sh));
    r = '0;
    lost = lost | (dp ? (|ms[10:0]) : (|ms[39:0]));
    r.data = dp ? {s, (sh != 6'h0) ? 11'h0 : bn[10:0], ms[62:11]}
                : {s, (sh != 6'h0) ? 8'h0 : bn[7:0], ms[62:40], WORD_RST};
    if (!wrap && bn >= emax)
    begin
      r.data = dp ? {s, 11'h7ff, 52'h0} : {s, 8'hff, 23'h0, WORD_RST};
      r.flags.overflow = 1'b1;
      lost = 1'b1;
    end
    if (m == 64'h0)
    begin
      r.data = {s, 63'h0};
      lost = 1'b0;
    end
    r.flags.inexact = lost;
    r.flags.underflow = lost && (sh != 6'h0);
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Captured instruction and operand registers.

  fsa_state_t  state;
  fsa_state_t  next_state;
  fsa_instr_t  instr;
  logic [31:0] a_hi;
  logic [31:0] a_lo;
  logic [31:0] b_hi;
  logic [31:0] b_lo;
  fsa_result_t exec_res;
  fsa_result_t f2i_res;

  // Mode decode straight from the pins for the request being offered.
  // mode decode
  wire fsa_mode_t req_mode = instr_i.chained_select_bit ? MODE_CHAINED :
                             instr_i.output_source_bit ? MODE_MULT : MODE_ALU;
  // Only the single-operand ALU path lives here; other modes are refused.
  // single-operand select
  wire req_ok = (req_mode == MODE_ALU) && instr_i.operand_count_bit;
  // A double-precision A operand (float formats only), or a precision conversion, takes a
  // second load edge for the low word.
  // two-edge load
  wire req_two = !instr_i.format_select_bit &&
                 (instr_i.a_precision_bit || instr_i.op_code == OP_F2F);
  wire take = (state == ST_IDLE) && instr_valid_i;

  // Sequencer: idle, optional low-word load, then one execute cycle.
  // mixed-precision sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE: if (instr_valid_i && req_ok) next_state = req_two ? ST_LOW : ST_EXEC;
      ST_LOW:  next_state = ST_EXEC;
      ST_EXEC: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i) state <= ST_IDLE;
    else        state <= next_state;
  end

  // Upper words, instruction and shift count are taken with the request; low
  // words follow on the second load edge and are cleared for single loads.
  // shift count capture
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      instr <= '0;
      a_hi  <= WORD_RST;
      b_hi  <= WORD_RST;
      a_lo  <= WORD_RST;
      b_lo  <= WORD_RST;
    end
    else if (take)
    begin
      instr <= instr_i;
      a_hi  <= operand_a_data_i;
      b_hi  <= operand_b_data_bus_i;
      a_lo  <= WORD_RST;
      b_lo  <= WORD_RST;
    end
    else if (state == ST_LOW)
    begin
      a_lo <= operand_a_data_i;
      b_lo <= operand_b_data_bus_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand unpacking. A single-precision operand is read from the upper half.

  wire a_dp = instr.a_precision_bit;
  wire [63:0] a_word = a_dp ? {a_hi, a_lo} : {a_hi, WORD_RST};
  wire [63:0] b_word = a_dp ? {b_hi, b_lo} : {b_hi, WORD_RST};
  wire a_sign = instr.abs_a_select_bit ? 1'b0 : a_hi[31];
  wire [63:0] a_abs = {a_sign, a_word[62:0]};
  wire [13:0] a_efield = a_dp ? {3'h0, a_hi[30:20]} : {6'h0, a_hi[30:23]};
  wire a_den = (a_efield == 14'h0);
  wire signed [13:0] a_emax = a_dp ? DP_EMAX : SP_EMAX;
  wire signed [13:0] a_bias = a_dp ? DP_BIAS : SP_BIAS;
  wire signed [13:0] o_bias = a_dp ? SP_BIAS : DP_BIAS;
  wire signed [13:0] a_be = a_den ? 14'sh0001 : $signed(a_efield);
  wire [51:0] a_frac = a_dp ? {a_hi[19:0], a_lo} : {a_hi[22:0], 29'h0};
  wire a_special = ($signed(a_efield) == a_emax);
  wire a_nan = a_special && (a_frac != 52'h0);
  wire [63:0] a_mant = {~a_den, a_frac, 11'h0};
  // Wrapped operands carry a signed exponent field and a hidden one.
  wire signed [13:0] a_wbe = a_dp ? 14'($signed(a_hi[30:20])) : 14'($signed(a_hi[30:23]));

  // Integer to float: the signed code takes the magnitude first.
  // result precision
  wire i2f_neg = (instr.op_code == OP_I2F) && a_hi[31];
  wire [31:0] i2f_mag = i2f_neg ? 32'h0 - a_hi : a_hi;
  wire fsa_result_t i2f_res = pack_fp(i2f_neg, a_bias + INT_TOP, {i2f_mag, WORD_RST},
                                      a_dp, 1'b0);
  wire fsa_result_t f2f_res = pack_fp(a_sign, a_be - a_bias + o_bias, a_mant, !a_dp, 1'b0);
  wire fsa_result_t wrap_res = pack_fp(a_sign, a_be, a_mant, a_dp, 1'b1);
  wire fsa_result_t unw_res = pack_fp(a_sign, a_wbe, {1'b1, a_frac, 11'h0}, a_dp, 1'b0);
  wire [7:0] shamt = b_hi[7:0];
  wire [4:0] int_op = {instr.abs_a_select_bit, instr.op_code};

  // Float to integer: align the mantissa to the integer point, then range
  // check. Infinity and NaN land in the out-of-range case and saturate.
  logic [63:0]        f2i_mag;
  logic               f2i_lost;
  logic               f2i_bad;
  logic [5:0]         f2i_sh;
  wire signed [13:0]  f2i_e = a_be - a_bias;
  wire                f2i_uns = (instr.op_code == OP_F2U);
  always_comb
  begin
    f2i_mag = 64'h0;
    f2i_lost = |a_mant;
    f2i_sh = 6'(MANT_TOP - f2i_e);
    f2i_res = '0;
    if (f2i_e > MANT_TOP)
    begin
      f2i_mag = 64'hffff_ffff_ffff_ffff;
      f2i_lost = 1'b0;
    end
    else if (f2i_e >= 14'sh0000)
    begin
      f2i_mag = a_mant >> f2i_sh;
      f2i_lost = |(a_mant & ~(64'hffff_ffff_ffff_ffff << f2i_sh));
    end
    f2i_bad = f2i_uns ? ((|f2i_mag[63:32]) || (a_sign && f2i_mag != 64'h0))
                      : (f2i_mag > (a_sign ? 64'h8000_0000 : 64'h7fff_ffff));
    if (f2i_bad)
    begin
      f2i_res.data[63:32] = f2i_uns ? 32'hffff_ffff : (a_sign ? 32'h8000_0000 : 32'h7fff_ffff);
      f2i_res.flags.invalid = 1'b1;
    end
    else
    begin
      f2i_res.data[63:32] = a_sign ? 32'h0 - f2i_mag[31:0] : f2i_mag[31:0];
      f2i_res.flags.inexact = f2i_lost;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation select for the execute cycle.

  always_comb
  begin
    exec_res = '0;
    if (instr.format_select_bit)
    begin
      case (int_op)
        IOP_PASS_A: exec_res.data[63:32] = a_hi;
        IOP_NEG_A:  exec_res.data[63:32] = 32'h0 - a_hi;
        IOP_NOT_A:  exec_res.data[63:32] = ~a_hi;
        IOP_PASS_B: exec_res.data[63:32] = b_hi;
        IOP_SLL:    exec_res.data[63:32] = a_hi << shamt;
        IOP_SRL:    exec_res.data[63:32] = a_hi >> shamt;
        IOP_SRA:    exec_res.data[63:32] = 32'($signed(a_hi) >>> shamt);
        default:    exec_res.flags.invalid = 1'b1;
      endcase
    end
    else
    begin
      case (instr.op_code)
        OP_PASS_A:
        begin
          exec_res.data = a_abs;
          exec_res.flags.invalid = a_nan;
        end
        OP_NEG_A:
        begin
          exec_res.data = {~a_sign, a_word[62:0]};
          exec_res.flags.invalid = a_nan;
        end
        OP_MOVE:   exec_res.data = a_abs;
        OP_PASS_B: exec_res.data = b_word;
        OP_I2F, OP_U2F: exec_res = i2f_res;
        OP_F2I, OP_F2U: exec_res = f2i_res;
        OP_F2F:
        begin
          exec_res = f2f_res;
          // Infinity and NaN keep their class; a NaN stays quiet.
          if (a_special)
            exec_res.data = a_dp ? {a_sign, 8'hff, a_nan, 22'h0, WORD_RST}
                                 : {a_sign, 11'h7ff, a_nan, 51'h0};
          exec_res.flags.invalid = a_nan;
        end
        OP_WRAP: exec_res = wrap_res;
        OP_UNW_EXACT: exec_res = unw_res;
        // The inexact and rounded forms always signal underflow, since the
        // value already lost bits when the multiplier produced it.
        OP_UNW_INEX, OP_UNW_RND:
        begin
          exec_res = unw_res;
          exec_res.flags.underflow = 1'b1;
          exec_res.flags.inexact = 1'b1;
        end
        default: exec_res.flags.invalid = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers.

  // Result holds to the next execute cycle, mode to the next take; valid and refusal pulse.
  // mode report
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      result_o       <= '0;
      result_valid_o <= 1'b0;
      mode_o         <= MODE_ALU;
      unsupported_o  <= 1'b0;
    end
    else
    begin
      result_valid_o <= (state == ST_EXEC);
      unsupported_o  <= take && !req_ok;
      if (state == ST_EXEC) result_o <= exec_res;
      if (take) mode_o <= req_mode;
    end
  end

  assign ready_o = (state == ST_IDLE);

endmodule

`default_nettype wire

// File: rtl/fsa_pkg.sv
// Constants, instruction and result layouts for the single-operand ALU block.
`default_nettype none

package fsa_pkg;

  // Floating-point operation codes (low four instruction bits).
  localparam logic [3:0] OP_PASS_A    = 4'h0;
  localparam logic [3:0] OP_NEG_A     = 4'h1;
  localparam logic [3:0] OP_I2F       = 4'h2;
  localparam logic [3:0] OP_F2I       = 4'h3;
  localparam logic [3:0] OP_MOVE      = 4'h4;
  localparam logic [3:0] OP_PASS_B    = 4'h5;
  localparam logic [3:0] OP_F2F       = 4'h6;
  localparam logic [3:0] OP_F2U       = 4'h7;
  localparam logic [3:0] OP_WRAP      = 4'h8;
  localparam logic [3:0] OP_U2F       = 4'ha;
  localparam logic [3:0] OP_UNW_EXACT = 4'hc;
  localparam logic [3:0] OP_UNW_INEX  = 4'hd;
  localparam logic [3:0] OP_UNW_RND   = 4'he;

  // Integer operation codes (low five instruction bits).
  localparam logic [4:0] IOP_PASS_A = 5'h00;
  localparam logic [4:0] IOP_NEG_A  = 5'h01;
  localparam logic [4:0] IOP_NOT_A  = 5'h02;
  localparam logic [4:0] IOP_PASS_B = 5'h05;
  localparam logic [4:0] IOP_SLL    = 5'h08;
  localparam logic [4:0] IOP_SRL    = 5'h09;
  localparam logic [4:0] IOP_SRA    = 5'h0d;

  // Exponent biases, largest biased exponents and fixed bit positions.
  localparam logic signed [13:0] DP_BIAS  = 14'sh03ff;
  localparam logic signed [13:0] SP_BIAS  = 14'sh007f;
  localparam logic signed [13:0] DP_EMAX  = 14'sh07ff;
  localparam logic signed [13:0] SP_EMAX  = 14'sh00ff;
  localparam logic signed [13:0] INT_TOP  = 14'sh001f;
  localparam logic signed [13:0] MANT_TOP = 14'sh003f;

  // Values after reset.
  localparam logic [31:0] WORD_RST = 32'h0;

  // Instruction word, highest bit first.
  typedef struct packed {
    logic       chained_select_bit;
    logic       format_select_bit;
    logic       a_precision_bit;
    logic       b_precision_bit;
    logic       output_source_bit;
    logic       operand_count_bit;
    logic       abs_a_select_bit;
    logic [3:0] op_code;
  } fsa_instr_t;

  typedef struct packed {
    logic invalid;
    logic overflow;
    logic underflow;
    logic inexact;
  } fsa_flags_t;

  typedef struct packed {
    logic [63:0] data;
    fsa_flags_t  flags;
  } fsa_result_t;

  typedef enum logic [1:0] {
    MODE_ALU     = 2'h0,
    MODE_MULT    = 2'h1,
    MODE_CHAINED = 2'h2
  } fsa_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW  = 3'b010,
    ST_EXEC = 3'b100
  } fsa_state_t;

endpackage

`default_nettype wire

// File: dv/fsa_ctrl_model.sv
// Controller model that offers instructions and operand words to the ALU.
`default_nettype none
module fsa_ctrl_model
  import fsa_pkg::*;
(
  input  wire logic               sys_clk_i,
  input  wire logic               ready_i,
  output var logic                instr_valid_o,
  output var fsa_pkg::fsa_instr_t instr_o,
  output var logic [31:0]         a_o,
  output var logic [31:0]         b_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quiet bus before the first request.
  initial
  begin
    instr_valid_o = 1'b0;
    instr_o = '0;
    a_o = 32'h0;
    b_o = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offer one request, just after an edge, and hold it until it is taken.
  // upper words with instruction.
  task automatic issue(input fsa_instr_t ins, input logic [63:0] a, input logic [63:0] b);
    logic two;
    two = !ins.format_select_bit && (ins.a_precision_bit || ins.op_code == OP_F2F);
    instr_valid_o = 1'b1;
    instr_o = ins;
    a_o = a[63:32];
    b_o = b[63:32];
    do @(posedge sys_clk_i); while (ready_i !== 1'b1);
    #1;
    instr_valid_o = 1'b0;
    if (two)
    begin
      a_o = a[31:0];
      b_o = b[31:0];
      @(posedge sys_clk_i);
      #1;
    end
    // Released words are inverted so a stale value cannot pass for a live one.
    a_o = ~a_o;
    b_o = ~b_o;
  endtask
endmodule
`default_nettype wire

// File: dv/fsa_alu_properties.sv
// Concurrent checks on the single-operand ALU ports.
`default_nettype none
module fsa_alu_properties
  import fsa_pkg::*;
(
  input wire logic                 sys_clk_i,
  input wire logic                 srst_i,
  input wire logic                 instr_valid_i,
  input wire fsa_pkg::fsa_instr_t  instr_i,
  input wire logic [31:0]          operand_a_data_i,
  input wire logic [31:0]          operand_b_data_bus_i,
  input wire logic                 ready_o,
  input wire fsa_pkg::fsa_result_t result_o,
  input wire logic                 result_valid_o,
  input wire fsa_pkg::fsa_mode_t   mode_o,
  input wire logic                 unsupported_o
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  // Decoded view of the request on offer.
  wire logic good = !instr_i.chained_select_bit && !instr_i.output_source_bit
                    && instr_i.operand_count_bit;
  wire logic two = !instr_i.format_select_bit
                   && (instr_i.a_precision_bit || instr_i.op_code == OP_F2F);
  wire logic [1:0] want_mode = instr_i.chained_select_bit ? 2'h2
                               : (instr_i.output_source_bit ? 2'h1 : 2'h0);
  wire logic is_move = !instr_i.format_select_bit && instr_i.op_code == OP_MOVE;

  sequence s_take; ready_o && instr_valid_i; endsequence
  sequence s_short; s_take ##0 (good && !two); endsequence
  sequence s_long; s_take ##0 (good && two); endsequence
  sequence s_answer; result_valid_o && ready_o; endsequence
  sequence s_refused; unsupported_o && ready_o && !result_valid_o; endsequence

  ////////////////////////////////////////////////////////////////////////////
  chk_mode_follows: assert property (s_take |=> mode_o == $past(want_mode))
    else $error("mode does not follow taken request");
  chk_refuse_pulse: assert property (s_take ##0 !good |=> s_refused)
    else $error("refused request not flagged");
  chk_busy_silent: assert property (!ready_o |-> !unsupported_o)
    else $error("refusal flagged while busy");
  chk_short_answer: assert property (s_short |=> !ready_o ##1 s_answer)
    else $error("single load answer not two cycles after take");
  chk_long_answer: assert property (s_long |=> !ready_o [*2] ##1 s_answer)
    else $error("two load answer not three cycles after take");
  chk_upper_only: assert property (s_short |-> ##2 result_o.data[31:0] == 32'h0)
    else $error("single word result leaks into lower word");
  chk_move_quiet: assert property (s_short ##0 is_move |-> ##2 result_o.flags == 4'h0)
    else $error("move raised a flag");
  chk_result_hold: assert property (!result_valid_o |-> $stable(result_o))
    else $error("result changed without valid pulse");
endmodule

bind fsa_alu fsa_alu_properties chk_u (
  .sys_clk_i            (sys_clk_i),
  .srst_i               (srst_i),
  .instr_valid_i        (instr_valid_i),
  .instr_i              (instr_i),
  .operand_a_data_i     (operand_a_data_i),
  .operand_b_data_bus_i (operand_b_data_bus_i),
  .ready_o              (ready_o),
  .result_o             (result_o),
  .result_valid_o       (result_valid_o),
  .mode_o               (mode_o),
  .unsupported_o        (unsupported_o)
);
`default_nettype wire

// File: dv/test_fsa_alu.sv
// Self-checking bench for the single-operand ALU.
`default_nettype none
module test_fsa_alu
  import fsa_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk;
  logic        srst;
  logic        valid;
  fsa_instr_t  instr;
  logic [31:0] a_word;
  logic [31:0] b_word;
  logic        ready;
  fsa_result_t result;
  logic        rvalid;
  fsa_mode_t   mode;
  logic        unsup;
  int          error_cnt;
  int          checks_done;

  fsa_alu dut_u (
    .sys_clk_i            (sys_clk),
    .srst_i               (srst),
    .instr_valid_i        (valid),
    .instr_i              (instr),
    .operand_a_data_i     (a_word),
    .operand_b_data_bus_i (b_word),
    .ready_o              (ready),
    .result_o             (result),
    .result_valid_o       (rvalid),
    .mode_o               (mode),
    .unsupported_o        (unsup)
  );

  fsa_ctrl_model ctrl_u (
    .sys_clk_i     (sys_clk),
    .ready_i       (ready),
    .instr_valid_o (valid),
    .instr_o       (instr),
    .a_o           (a_word),
    .b_o           (b_word)
  );

  // Free-running 125 MHz clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_data(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_ctl(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t control %h expected %h", $time, got, exp);
    end
  endtask

  // float single operand, B precision mirrors A.
  function automatic fsa_instr_t fi(input logic p, input logic [3:0] op);
    return '{1'b0, 1'b0, p, p, 1'b0, 1'b1, 1'b0, op};
  endfunction

  function automatic fsa_instr_t ii(input logic [4:0] op);
    return '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, op[4], op[3:0]};
  endfunction

  // Single words and integers live in the upper half, the lower half zero.
  function automatic logic [63:0] hi(input logic [31:0] w);
    return {w, 32'h0};
  endfunction

  // One request; the answer must land on the second edge after the model lets go.
  task automatic run(input fsa_instr_t ins, input logic [63:0] a, input logic [63:0] b,
                     input logic [63:0] exp, input logic [3:0] fl, input logic cd = 1'b1);
    int n;
    ctrl_u.issue(ins, a, b);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (rvalid !== 1'b1 && n < 8);
    chk_ctl(n[3:0], 4'h2);
    if (cd)
      chk_data(result.data, exp);
    chk_ctl(result.flags, fl);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_passes();
    fsa_instr_t ins;
    ins = fi(1'b0, OP_PASS_A);
    ins.abs_a_select_bit = 1'b1;
    run(fi(1'b0, OP_PASS_A), hi(32'h3f800000), 64'h0, hi(32'h3f800000), 4'h0);
    run(fi(1'b0, OP_NEG_A), hi(32'h3f800000), 64'h0, hi(32'hbf800000), 4'h0);
    run(ins, hi(32'hbf800000), 64'h0, hi(32'h3f800000), 4'h0);
    run(fi(1'b0, OP_PASS_B), 64'h0, hi(32'h40000000), hi(32'h40000000), 4'h0);
    run(fi(1'b0, OP_MOVE), hi(32'h7fc00000), 64'h0, hi(32'h7fc00000), 4'h0);
    run(fi(1'b1, OP_PASS_A), 64'h40000000_00000005, 64'h0, 64'h40000000_00000005, 4'h0);
    run(fi(1'b1, OP_PASS_B), 64'h0, 64'h40000000_00000005, 64'h40000000_00000005, 4'h0);
  endtask

  task automatic t_convert();
    run(fi(1'b0, OP_I2F), hi(32'hfffffffe), 64'h0, hi(32'hc0000000), 4'h0);
    run(fi(1'b0, OP_F2I), hi(32'hc0000000), 64'h0, hi(32'hfffffffe), 4'h0);
    run(fi(1'b0, OP_F2F), hi(32'h3f800000), 64'h0, hi(32'h3ff00000), 4'h0);
    run(fi(1'b1, OP_F2F), hi(32'h3ff00000), 64'h0, hi(32'h3f800000), 4'h0);
    run(fi(1'b0, OP_F2U), hi(32'h41200000), 64'h0, hi(32'h0000000a), 4'h0);
    run(fi(1'b0, OP_U2F), hi(32'h0000000a), 64'h0, hi(32'h41200000), 4'h0);
    run(fi(1'b1, OP_U2F), hi(32'h0000000a), 64'h0, hi(32'h40240000), 4'h0);
  endtask

  // Wrap a denormal, then unwrap it with each of the three unwrap codes; the rounded form checks only its flags.
  task automatic t_wrap();
    logic [63:0] w;
    run(fi(1'b0, OP_WRAP), hi(32'h00200000), 64'h0, hi(32'h7f800000), 4'h0);
    w = result.data;
    chk_ctl({3'h0, w[63:32] !== 32'h00200000}, 4'h1);
    run(fi(1'b0, OP_UNW_EXACT), w, 64'h0, 64'h00200000_00000000, 4'h0);
    run(fi(1'b0, OP_UNW_INEX), w, 64'h0, 64'h00200000_00000000, 4'h3);
    run(fi(1'b0, OP_UNW_RND), w, 64'h0, 64'h0, 4'h3, 1'b0);
  endtask

  // Count 0x104 must shift by four: only its low eight bits count.
  task automatic t_shift();
    run(ii(IOP_SLL), hi(32'h0000000f), hi(32'h00000104), hi(32'h000000f0), 4'h0);
    run(ii(IOP_SRL), hi(32'h80000000), hi(32'h00000104), hi(32'h08000000), 4'h0);
    run(ii(IOP_SRA), hi(32'h80000000), hi(32'h00000104), hi(32'hf8000000), 4'h0);
  endtask

  // Chained, multiplier and two-operand requests are refused with their mode.
  task automatic t_refuse();
    fsa_instr_t ins;
    for (int k = 0; k < 3; k++)
    begin
      ins = fi(1'b0, OP_PASS_A);
      ins.chained_select_bit = (k == 0);
      ins.output_source_bit = (k == 1);
      ins.operand_count_bit = (k != 2);
      ctrl_u.issue(ins, 64'h0, 64'h0);
      @(posedge sys_clk);
      chk_ctl({2'h0, unsup, ready}, 4'h3);
      chk_ctl({2'h0, mode}, 4'(2 - k));
      #1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence: reset, then every scenario in turn.
  initial
  begin
    error_cnt = 0;
    checks_done = 0;
    srst = 1'b1;
    repeat (16) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    @(posedge sys_clk);
    #1;
    // Idle, ready and reporting the ALU mode straight out of reset.
    chk_ctl({ready, rvalid, unsup, |mode}, 4'h8);
    chk_data(result.data, 64'h0);
    t_passes();
    t_convert();
    t_wrap();
    t_refuse();
    t_shift();
    end_of_test();
  end

  // A hang costs a mismatch; the run needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
